// ==== core/srap_regs.vh ====
// Register offsets, field values, reset values and timing for the serial port
`ifndef SRAP_REGS_VH
`define SRAP_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SRAP_ADDR_ID_LOW 7'h00
`define SRAP_ADDR_ID_HIGH 7'h01
`define SRAP_ADDR_CAL_W0 7'h04
`define SRAP_ADDR_CAL_W1 7'h05
`define SRAP_ADDR_CAL_W2 7'h06
`define SRAP_ADDR_STATUS 7'h0F
`define SRAP_ADDR_GUARD 7'h7E

// ****************************************************************
// Write guard codes and reset values
// ****************************************************************
`define SRAP_GUARD_PROTECTED 8'h00
`define SRAP_GUARD_OPEN 8'h01
`define SRAP_GUARD_SINGLE 8'h02
`define SRAP_GUARD_RESET 8'h00
`define SRAP_CAL_RESET 24'h00_0000
`define SRAP_STATUS_RESET 8'h00
`define SRAP_ID_LOW_VALUE 8'h5A
`define SRAP_ID_HIGH_VALUE 8'hC3

// ****************************************************************
// Frame layout and timing
// ****************************************************************
`define SRAP_RW_BIT 0
`define SRAP_ADDR_BITS 7
`define SRAP_FRAME_BITS 16
`define SRAP_HALF_PERIOD_MIN_NS 45
`define SRAP_CLK_PERIOD_NS 10

`endif

// ==== core/srap_sync.v ====
// Two-stage synchroniser for the serial port pins
`timescale 1ns/1ps
module srap_sync #(
  parameter WIDTH = 3
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      meta <= {WIDTH{1'b1}};
      sync_o <= {WIDTH{1'b1}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // srap_sync

// ==== core/srap_regfile.v ====
// Register store with the write guard and the three-word calibration value
`timescale 1ns/1ps
`include "srap_regs.vh"
module srap_regfile (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire wr_en_i,
  input wire [6:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  input wire [6:0] rd_addr_i,
  input wire [7:0] status_set_i,
  output reg [7:0] rd_data_o,
  output reg [7:0] guard_o,
  output reg [23:0] cal_o,
  output reg [7:0] status_o
);
  reg [7:0] cal_w0;
  reg [7:0] cal_w1;
  reg [1:0] cal_step;
  wire guard_hit;
  wire open_ok;
  wire w1c_only;

  assign guard_hit = (wr_addr_i == `SRAP_ADDR_GUARD);
  // Writes outside the guard pass only when unlocked
  assign open_ok = (guard_o == `SRAP_GUARD_OPEN) ||
                   (guard_o == `SRAP_GUARD_SINGLE);
  assign w1c_only = (wr_addr_i == `SRAP_ADDR_STATUS);

  // ****************************************************************
  // Write side
  // ****************************************************************
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      guard_o <= `SRAP_GUARD_RESET;
      cal_o <= `SRAP_CAL_RESET;
      cal_w0 <= 8'h00;
      cal_w1 <= 8'h00;
      cal_step <= 2'd0;
      status_o <= `SRAP_STATUS_RESET;
    end else begin
      // Set wins over a clear in the same cycle; zero bits leave it alone
      status_o <= status_o | status_set_i;
      if (wr_en_i && guard_hit) begin
        guard_o <= wr_data_i;
      end else if (wr_en_i && open_ok) begin
        if (w1c_only) begin
          // Clearing status does not spend the single allowance
          status_o <= (status_o & ~wr_data_i) | status_set_i;
        end else if (guard_o == `SRAP_GUARD_SINGLE) begin
          guard_o <= `SRAP_GUARD_PROTECTED;
        end
        // Calibration only takes effect on the third word in order
        if (wr_addr_i == `SRAP_ADDR_CAL_W0) begin
          cal_w0 <= wr_data_i;
          cal_step <= 2'd1;
        end else if (wr_addr_i == `SRAP_ADDR_CAL_W1 && cal_step == 2'd1) begin
          cal_w1 <= wr_data_i;
          cal_step <= 2'd2;
        end else if (wr_addr_i == `SRAP_ADDR_CAL_W2 && cal_step == 2'd2) begin
          cal_o <= {wr_data_i, cal_w1, cal_w0};
          cal_step <= 2'd0;
        end else begin
          cal_step <= 2'd0;
        end
      end
    end
  end

  // ****************************************************************
  // Registered read port
  // ****************************************************************
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
    end else begin
      case (rd_addr_i)
        `SRAP_ADDR_ID_LOW: rd_data_o <= `SRAP_ID_LOW_VALUE;
        `SRAP_ADDR_ID_HIGH: rd_data_o <= `SRAP_ID_HIGH_VALUE;
        `SRAP_ADDR_CAL_W0: rd_data_o <= cal_o[7:0];
        `SRAP_ADDR_CAL_W1: rd_data_o <= cal_o[15:8];
        `SRAP_ADDR_CAL_W2: rd_data_o <= cal_o[23:16];
        `SRAP_ADDR_STATUS: rd_data_o <= status_o;
        `SRAP_ADDR_GUARD: rd_data_o <= guard_o;
        default: rd_data_o <= 8'h00;
      endcase
    end
  end
endmodule // srap_regfile

// ==== core/srap_top.v ====
// Serial register access port: frame decoder and output driver
// Notes on behaviour
// - Registers are reached only through the serial port; no parallel bus.
// - Edge select low: read bits are launched on serial clock rising edges.
// - Edge select high: read bits are launched on serial clock falling edges.
// - Write data is sampled on the serial clock rising edge.
// - Serial data output goes high impedance once chip select rises.
// - Reset loads every register default before any access acts.
// - Protected mode ignores writes except to the write guard register.
// - Fully unprotected mode accepts writes to every writable register.
// - Single mode allows one write, then relocks; clearing status doesn't count.
// - Writing zero to a write-one-to-clear status bit leaves it unchanged.
// - New calibration applies only after all three words are written.
// - Offset 00 reads the low identification byte.
// - Offset 01 reads the high identification byte.
// - Write guard mode lives in an eight-bit register at 7E.
`timescale 1ns/1ps
`include "srap_regs.vh"
module srap_top (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire serial_clk_i,
  input wire chip_sel_n_i,
  input wire serial_data_in_i,
  input wire read_edge_select_i,
  input wire [7:0] status_event_i,
  output reg serial_data_out_o,
  output reg serial_data_out_oe_n_o,
  output reg [7:0] write_guard_o,
  output reg [23:0] calibration_o,
  output reg [7:0] status_o
);
  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  wire [3:0] pins_sync;
  wire sclk_s;
  wire csn_s;
  wire sdi_s;
  wire edge_sel_s;
  reg sclk_d;
  wire sclk_rise;
  wire sclk_fall;

  srap_sync #(.WIDTH(4)) u_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({read_edge_select_i, serial_data_in_i, chip_sel_n_i,
              serial_clk_i}),
    .sync_o(pins_sync)
  );

  assign sclk_s = pins_sync[0];
  assign csn_s = pins_sync[1];
  assign sdi_s = pins_sync[2];
  assign edge_sel_s = pins_sync[3];
  // Edges are taken from synchronised samples only
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;

  // ****************************************************************
  // Frame decoder
  // ****************************************************************
  localparam ST_IDLE = 2'd0;
  localparam ST_HEAD = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_DONE = 2'd3;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [4:0] bit_cnt;
  reg [7:0] shift_in;
  reg read_flag;
  reg [6:0] addr;
  reg [7:0] rd_shift;
  reg wr_en;
  wire [7:0] rd_data;
  wire [7:0] guard;
  wire [23:0] cal;
  wire [7:0] status;
  reg launch_first;

  // Next state of the frame tracker
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (!csn_s) next_state = ST_HEAD;
      ST_HEAD: begin
        if (csn_s) next_state = ST_IDLE;
        else if (bit_cnt == 5'd8) next_state = ST_DATA;
      end
      ST_DATA: begin
        if (csn_s) next_state = ST_IDLE;
        else if (bit_cnt == `SRAP_FRAME_BITS) next_state = ST_DONE;
      end
      ST_DONE: if (csn_s) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Bit capture on synchronised rising edges
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      sclk_d <= 1'b0;
      bit_cnt <= 5'd0;
      shift_in <= 8'h00;
      read_flag <= 1'b0;
      addr <= 7'h00;
      wr_en <= 1'b0;
      launch_first <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      state <= next_state;
      wr_en <= 1'b0;
      launch_first <= 1'b0;
      if (csn_s) begin
        bit_cnt <= 5'd0;
      end else if (sclk_rise && bit_cnt < `SRAP_FRAME_BITS) begin
        // Data is taken on the rising edge of the serial clock
        shift_in <= {shift_in[6:0], sdi_s};
        bit_cnt <= bit_cnt + 5'd1;
        if (bit_cnt == `SRAP_RW_BIT)
          read_flag <= sdi_s;
        if (bit_cnt == 5'd7) begin
          addr <= {shift_in[5:0], sdi_s};
          launch_first <= 1'b1;
        end
        // Only a completed write frame reaches the registers
        if (bit_cnt == 5'd15 && !read_flag)
          wr_en <= 1'b1;
      end
    end
  end

  srap_regfile u_regs (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(wr_en),
    .wr_addr_i(addr),
    .wr_data_i(shift_in),
    .rd_addr_i(addr),
    .status_set_i(status_event_i),
    .rd_data_o(rd_data),
    .guard_o(guard),
    .cal_o(cal),
    .status_o(status)
  );

  // ****************************************************************
  // Read data launch
  // ****************************************************************
  // The read port lags the address by a cycle; load a cycle later
  reg load_rd;
  wire launch_edge;

  // Edge select picks which serial clock edge shifts out the next bit
  assign launch_edge = edge_sel_s ? sclk_fall : sclk_rise;

  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      load_rd <= 1'b0;
      rd_shift <= 8'h00;
      serial_data_out_o <= 1'b0;
      serial_data_out_oe_n_o <= 1'b1;
    end else begin
      load_rd <= launch_first;
      if (csn_s) begin
        // Release the output as soon as the frame ends
        serial_data_out_oe_n_o <= 1'b1;
      end else if (load_rd && read_flag) begin
        rd_shift <= rd_data;
      end else if (read_flag && state == ST_DATA && launch_edge) begin
        serial_data_out_o <= rd_shift[7];
        serial_data_out_oe_n_o <= 1'b0;
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
    end
  end

  // Register copies keep every output straight from a flip-flop
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      write_guard_o <= `SRAP_GUARD_RESET;
      calibration_o <= `SRAP_CAL_RESET;
      status_o <= `SRAP_STATUS_RESET;
    end else begin
      write_guard_o <= guard;
      calibration_o <= cal;
      status_o <= status;
    end
  end
endmodule // srap_top

// ==== tb/srap_checker.sv ====
// Port checker for the serial register access port
`timescale 1ns/1ps
module srap_checker (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic serial_clk_i,
  input wire logic chip_sel_n_i,
  input wire logic serial_data_in_i,
  input wire logic read_edge_select_i,
  input wire logic [7:0] status_event_i,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe_n_o,
  input wire logic [7:0] write_guard_o,
  input wire logic [23:0] calibration_o,
  input wire logic [7:0] status_o
);
  // ********************
  // Port relations
  // ********************
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Output let go a few cycles after select rises
  property p_oe_release;
    $rose(chip_sel_n_i) |-> ##[1:6] serial_data_out_oe_n_o;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("output still driven after select rose");
  // Never driven outside a frame
  property p_idle_no_drive;
    chip_sel_n_i [*8] |-> serial_data_out_oe_n_o;
  endproperty
  a_idle_no_drive: assert property (p_idle_no_drive)
    else $error("output driven with no frame");
  // First edge after reset shows the output enable, guard, calibration and status defaults
  property p_rst_defaults;
    $fell(sys_rst_i) |-> serial_data_out_oe_n_o && write_guard_o == 8'h00
      && calibration_o == 24'h00_0000 && status_o == 8'h00;
  endproperty
  a_rst_defaults: assert property (p_rst_defaults)
    else $error("register default missing after reset");
  // Writes land only while a frame is open
  property p_cal_in_frame;
    $changed(calibration_o) |-> !$past(chip_sel_n_i, 4);
  endproperty
  a_cal_in_frame: assert property (p_cal_in_frame)
    else $error("calibration moved outside a frame");
  property p_guard_in_frame;
    $changed(write_guard_o) |-> !$past(chip_sel_n_i, 4);
  endproperty
  a_guard_in_frame: assert property (p_guard_in_frame)
    else $error("guard moved outside a frame");
  // Status bits fall only by a host write
  property p_status_clear;
    |($past(status_o) & ~status_o) |-> !$past(chip_sel_n_i, 4);
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status bit fell without a write");
  // Read bits move only a few cycles after the chosen edge
  property p_launch_rise;
    !read_edge_select_i && !serial_data_out_oe_n_o
      && !$past(serial_data_out_oe_n_o) && $changed(serial_data_out_o)
      |-> $past(serial_clk_i, 2);
  endproperty
  a_launch_rise: assert property (p_launch_rise)
    else $error("read bit moved away from a rising edge");
  property p_launch_fall;
    read_edge_select_i && !serial_data_out_oe_n_o
      && !$past(serial_data_out_oe_n_o) && $changed(serial_data_out_o)
      |-> !$past(serial_clk_i, 2);
  endproperty
  a_launch_fall: assert property (p_launch_fall)
    else $error("read bit moved away from a falling edge");
endmodule // srap_checker
bind srap_top srap_checker i_chk (.ref_clk_i, .sys_rst_i, .serial_clk_i,
  .chip_sel_n_i, .serial_data_in_i, .read_edge_select_i, .status_event_i,
  .serial_data_out_o, .serial_data_out_oe_n_o, .write_guard_o,
  .calibration_o, .status_o);

// ==== tb/srap_host_model.sv ====
// Host processor model that runs serial frames
`timescale 1ns/1ps
module srap_host_model (
  input wire logic ref_clk_i,
  input wire logic read_edge_select_i,
  input wire logic serial_data_out_i,
  output logic serial_clk_o,
  output logic chip_sel_n_o,
  output logic serial_data_in_o
);
  // ********************
  // Frame engine
  // ********************
  localparam int HALF = 8; // 80 ns phases, above the read minimum
  initial begin
    serial_clk_o = 1'b0;
    chip_sel_n_o = 1'b1;
    serial_data_in_o = 1'b0;
  end
  // Flag, address, data MSB first; clock still outside frames
  task automatic xfer(input logic rd, input logic [6:0] a,
    input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a, d};
    q = 8'h00;
    @(posedge ref_clk_i) chip_sel_n_o <= 1'b0;
    repeat (HALF) @(posedge ref_clk_i);
    for (int i = 15; i >= 0; i--) begin
      serial_data_in_o <= f[i]; // Set up a phase before the rise
      repeat (HALF - 1) @(posedge ref_clk_i);
      if (i < 8 && read_edge_select_i) q[i] = serial_data_out_i;
      @(posedge ref_clk_i) serial_clk_o <= 1'b1;
      repeat (HALF - 1) @(posedge ref_clk_i);
      if (i < 8 && !read_edge_select_i) q[i] = serial_data_out_i;
      @(posedge ref_clk_i) serial_clk_o <= 1'b0;
    end
    repeat (HALF) @(posedge ref_clk_i);
    chip_sel_n_o <= 1'b1;
    serial_data_in_o <= ~serial_data_in_o; // Released line is not kept
    repeat (HALF) @(posedge ref_clk_i);
  endtask
endmodule // srap_host_model

// ==== tb/tb.sv ====
// Self-checking bench for the serial register access port
`timescale 1ns/1ps
`include "srap_regs.vh"
module tb;
  typedef struct {logic es; logic rd; logic [6:0] a; logic [7:0] d;
    logic [7:0] e;} srap_row_t;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic edge_sel = 1'b0;
  logic [7:0] status_event = 8'h00;
  logic [7:0] q;
  wire sclk, cs_n, serial_data_in, serial_data_out, oe_n;
  wire [7:0] guard, status;
  wire [23:0] cal;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  srap_row_t rows [16];
  // ********************
  // Clock, parts, helpers
  // ********************
  always #5 ref_clk_i = ~ref_clk_i;
  srap_top i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .serial_clk_i(sclk), .chip_sel_n_i(cs_n), .serial_data_in_i(serial_data_in),
    .read_edge_select_i(edge_sel), .status_event_i(status_event),
    .serial_data_out_o(serial_data_out), .serial_data_out_oe_n_o(oe_n),
    .write_guard_o(guard), .calibration_o(cal), .status_o(status));
  srap_host_model i_host (.ref_clk_i(ref_clk_i),
    .read_edge_select_i(edge_sel), .serial_data_out_i(serial_data_out),
    .serial_clk_o(sclk), .chip_sel_n_o(cs_n), .serial_data_in_o(serial_data_in));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.xfer(1'b0, a, d, q);
    repeat (6) @(posedge ref_clk_i);
  endtask
  task summarize;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, well above the roughly 7k cycles needed
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      summarize;
    end
  end
  // ********************
  // Main sequence
  // ********************
  initial begin
    rows = '{'{1'b0, 1'b1, 7'h7E, 8'h00, 8'h00},
      '{1'b1, 1'b1, 7'h00, 8'h00, `SRAP_ID_LOW_VALUE},
      '{1'b0, 1'b1, 7'h01, 8'h00, `SRAP_ID_HIGH_VALUE},
      '{1'b0, 1'b0, 7'h05, 8'h11, 8'h00}, '{1'b1, 1'b1, 7'h05, 8'h00, 8'h00},
      '{1'b0, 1'b0, 7'h7E, 8'h01, 8'h00}, '{1'b1, 1'b1, 7'h7E, 8'h00, 8'h01},
      '{1'b0, 1'b0, 7'h04, 8'hA1, 8'h00}, '{1'b0, 1'b0, 7'h05, 8'hB2, 8'h00},
      '{1'b0, 1'b0, 7'h06, 8'hC3, 8'h00}, '{1'b0, 1'b1, 7'h04, 8'h00, 8'hA1},
      '{1'b1, 1'b1, 7'h05, 8'h00, 8'hB2}, '{1'b0, 1'b1, 7'h06, 8'h00, 8'hC3},
      '{1'b0, 1'b0, 7'h00, 8'hFF, 8'h00},
      '{1'b1, 1'b1, 7'h00, 8'h00, `SRAP_ID_LOW_VALUE},
      '{1'b0, 1'b1, 7'h33, 8'h00, 8'h00}};
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    check(guard, `SRAP_GUARD_RESET);
    // Guard read first, then ID bytes, a locked write, unlock, calibration 04, 05, 06
    for (int k = 0; k < 16; k++) begin
      edge_sel <= rows[k].es;
      i_host.xfer(rows[k].rd, rows[k].a, rows[k].d, q);
      if (rows[k].rd) check(q, rows[k].e);
      check(oe_n, 1'b1);
    end
    check(cal, 24'hC3_B2A1);
    // Two words alone must not touch the applied value
    wr(7'h04, 8'h11);
    wr(7'h05, 8'h22);
    check(cal, 24'hC3_B2A1);
    wr(7'h06, 8'h33);
    check(cal, 24'h33_2211);
    // Single mode: clearing status keeps the allowance, then relock
    wr(7'h7E, `SRAP_GUARD_SINGLE);
    status_event <= 8'h80;
    @(posedge ref_clk_i) status_event <= 8'h00;
    wr(7'h0F, 8'h00); // Writing zero leaves the set bit unchanged
    check(status, 8'h80);
    wr(7'h0F, 8'h80);
    check({status, guard}, {8'h00, `SRAP_GUARD_SINGLE});
    wr(7'h05, 8'h44);
    check(guard, `SRAP_GUARD_PROTECTED);
    // Locked again: a clear must now be ignored
    status_event <= 8'h80;
    @(posedge ref_clk_i) status_event <= 8'h00;
    wr(7'h0F, 8'h80);
    check(status, 8'h80);
    // Reset in mid-run restores the calibration and status defaults
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    check({cal, status}, {`SRAP_CAL_RESET, `SRAP_STATUS_RESET});
    summarize;
  end
endmodule // tb
